/* rtl/system_tick_and_task_timers.sv */
/*
  periodic tick unit (five reloading channels, one on the crystal clock) and
  task monitor unit (prescaled up counter with four compare interrupts).
  assumes core_clk is the system clock; xtal_clk is much slower and is sampled.
  configuration arrives on plain ports; there is no software bus here.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - five independent tick channels each hold a 32-bit down counter that reloads itself.
// - channels 0 to 3 count system clocks and channel 4 counts crystal clock edges.
// - the crystal channel keeps counting in stop mode and its expiry requests a clock restart.
// - at zero a channel raises an interrupt, a converter queue trigger, both, or neither, as set.
// - the tick unit has no pins; only clocks, control ports, interrupts and triggers.
// - the task monitor has one 32-bit up counter advanced through an 8-bit prescaler.
// - four 32-bit compare channels each interrupt when the counter passes their value.
// - the task monitor counter can optionally freeze while the processor is debug halted.
module system_tick_and_task_timers (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // crystal clock sampled as a level
  input wire logic xtal_clk,
  // power and debug state
  input wire logic stop_mode,
  input wire logic debug_halt,
  // tick unit control
  input wire logic [4:0] tick_enable,
  input wire logic [4:0][31:0] tick_load,
  input wire logic [4:0] tick_irq_enable,
  input wire logic [4:0] tick_trig_enable,
  input wire logic [4:0] tick_flag_clear,
  // tick unit status and events
  output logic [4:0][31:0] tick_count,
  output logic [4:0] tick_flag,
  output logic [4:0] tick_irq,
  output logic [4:0] tick_trigger,
  output logic wake_request,
  // task monitor control
  input wire logic monitor_enable,
  input wire logic [7:0] monitor_prescale,
  input wire logic monitor_debug_freeze,
  input wire logic [3:0] cmp_enable,
  input wire logic [3:0][31:0] cmp_value,
  input wire logic [3:0] cmp_flag_clear,
  // task monitor status and events
  output logic [31:0] monitor_count,
  output logic [3:0] cmp_flag,
  output logic [3:0] cmp_irq
);
  // ----------------------------------------------------------------
  // crystal clock sampling
  // ----------------------------------------------------------------
  // the crystal must stay well below a quarter of core_clk, or rises are lost
  // in the three sampling stages; nothing flags such a loss
  logic [2:0] xtal_sync;
  logic xtal_level;
  logic [2:0] next_xtal_sync;
  logic next_xtal_level;
  logic xtal_rise;

  always_comb begin
    next_xtal_sync = {xtal_sync[1:0], xtal_clk};
    next_xtal_level = xtal_level;
    xtal_rise = 1'b0;
    // stage 0 feeds only stage 1; the edge looks at stages 1 and 2
    if (xtal_sync[1] == xtal_sync[2]) begin
      next_xtal_level = xtal_sync[2];
      xtal_rise = xtal_sync[2] && !xtal_level;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xtal_sync <= sys_timer_pkg::SYNC_RST;
      xtal_level <= 1'b0;
    end else begin
      xtal_sync <= next_xtal_sync;
      xtal_level <= next_xtal_level;
    end
  end

  // ----------------------------------------------------------------
  // periodic tick unit
  // ----------------------------------------------------------------
  // channel 4 steps once per sampled crystal rise, so its period is counted
  // in crystal cycles; a disabled channel preloads its load value, so the
  // first period after enabling is a full one
  logic [4:0] tick_step;
  logic [4:0] tick_expired;

  always_comb begin
    // system clocked channels stop with the system clock in stop mode
    tick_step = {xtal_rise, {sys_timer_pkg::NUM_SYS_TICK{!stop_mode}}};
  end

  genvar ch;
  generate
    for (ch = 0; ch < sys_timer_pkg::NUM_TICK; ch++) begin : g_tick
      tick_channel u_tick (
        .core_clk(core_clk),
        .resetn(resetn),
        .enable(tick_enable[ch]),
        .step(tick_step[ch]),
        .load_value(tick_load[ch]),
        .irq_enable(tick_irq_enable[ch]),
        .trig_enable(tick_trig_enable[ch]),
        .flag_clear(tick_flag_clear[ch]),
        .count(tick_count[ch]),
        .flag(tick_flag[ch]),
        .irq(tick_irq[ch]),
        .trigger(tick_trigger[ch]),
        .expired(tick_expired[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // wake-up request
  // ----------------------------------------------------------------
  // only the crystal channel may wake; it is the one clock left in stop
  logic next_wake_request;

  always_comb begin
    // held until stop mode is left so a slow clock restart still sees it
    next_wake_request = stop_mode &&
      (wake_request || tick_expired[sys_timer_pkg::WAKE_CHAN]);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= next_wake_request;
    end
  end

  // ----------------------------------------------------------------
  // task monitor unit
  // ----------------------------------------------------------------
  // the prescaler restarts on every counter step, so the divide ratio is
  // prescale plus one; lowering the prescale below the running count waits
  // for the 8-bit wrap before the next step
  logic [7:0] prescale_count;
  logic [7:0] next_prescale_count;
  logic [31:0] next_monitor_count;
  logic run;
  logic advance;

  always_comb begin
    run = monitor_enable && !(monitor_debug_freeze && debug_halt);
    advance = run && (prescale_count == monitor_prescale);
    next_prescale_count = prescale_count;
    next_monitor_count = monitor_count;
    if (run) begin
      if (advance) begin
        next_prescale_count = sys_timer_pkg::PRESCALE_RST;
        next_monitor_count = monitor_count + 32'h0000_0001;
      end else begin
        next_prescale_count = prescale_count + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_count <= sys_timer_pkg::PRESCALE_RST;
      monitor_count <= sys_timer_pkg::COUNT_RST;
    end else begin
      prescale_count <= next_prescale_count;
      monitor_count <= next_monitor_count;
    end
  end

  // ----------------------------------------------------------------
  // compare channels
  // ----------------------------------------------------------------
  // a frozen counter never steps, so no compare can fire while halted with monitor_debug_freeze set
  logic [3:0] next_cmp_flag;
  logic [3:0] next_cmp_irq;

  always_comb begin
    for (int i = 0; i < sys_timer_pkg::NUM_CMP; i++) begin
      // passing means stepping away from the compare value; set beats clear
      next_cmp_flag[i] = (cmp_enable[i] && advance && monitor_count == cmp_value[i]) ||
        (cmp_flag[i] && !cmp_flag_clear[i]);
      next_cmp_irq[i] = next_cmp_flag[i] && cmp_enable[i];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_flag <= 4'h0;
      cmp_irq <= 4'h0;
    end else begin
      cmp_flag <= next_cmp_flag;
      cmp_irq <= next_cmp_irq;
    end
  end
endmodule
`default_nettype wire

/* pkg/sys_timer_pkg.sv */
/*
  constants shared by the tick and task monitor timers.
  assumes a single system clock domain; the crystal clock is sampled as a pin.
*/
package sys_timer_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_TICK = 5;
  localparam int NUM_SYS_TICK = 4;
  localparam int WAKE_CHAN = 4;
  localparam int NUM_CMP = 4;
  localparam int CNT_W = 32;
  localparam int PRE_W = 8;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h0;
endpackage

/* rtl/tick_channel.sv */
/*
  one reloading down counter channel of the periodic tick unit.
  assumes step is synchronous to core_clk (one count per high cycle) and config is stable while enabled.
*/
`timescale 1ns/1ns
`default_nettype none
module tick_channel (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic enable,
  input wire logic step,
  input wire logic [31:0] load_value,
  input wire logic irq_enable,
  input wire logic trig_enable,
  input wire logic flag_clear,
  // status and events
  output logic [31:0] count,
  output logic flag,
  output logic irq,
  output logic trigger,
  output logic expired
);
  logic [31:0] next_count;
  logic next_flag;
  logic next_irq;
  logic next_trigger;
  logic next_expired;
  logic hit;

  always_comb begin
    hit = enable && step && (count == sys_timer_pkg::COUNT_RST);
    next_count = count;
    if (!enable) begin
      next_count = load_value;
    end else if (hit) begin
      next_count = load_value;
    end else if (step) begin
      next_count = count - 32'h0000_0001;
    end
    // set wins over clear so no expiry is lost
    next_flag = hit || (flag && !flag_clear);
    next_irq = next_flag && irq_enable;
    next_trigger = hit && trig_enable;
    next_expired = hit;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= sys_timer_pkg::COUNT_RST;
      flag <= 1'b0;
      irq <= 1'b0;
      trigger <= 1'b0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      flag <= next_flag;
      irq <= next_irq;
      trigger <= next_trigger;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

/* test/timers_props.sv */
/* checker for the tick and task monitor timers.
   sees only top ports; bound at the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module timers_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic stop_mode,
  input wire logic debug_halt,
  input wire logic monitor_debug_freeze,
  input wire logic [4:0] tick_enable,
  input wire logic [4:0][31:0] tick_load,
  input wire logic [4:0][31:0] tick_count,
  input wire logic [4:0] tick_flag,
  input wire logic [4:0] tick_flag_clear,
  input wire logic [4:0] tick_irq,
  input wire logic [4:0] tick_trigger,
  input wire logic wake_request,
  input wire logic [31:0] monitor_count,
  input wire logic [3:0][31:0] cmp_value,
  input wire logic [3:0] cmp_flag,
  input wire logic [3:0] cmp_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  trig_pulse_a: assert property (tick_trigger[0] |=> !tick_trigger[0])
    else $error("trigger longer than one cycle");
  reload_a: assert property (tick_trigger[0] |-> tick_count[0] == tick_load[0])
    else $error("no reload on expiry");
  expiry_a: assert property (tick_trigger[0] |-> $past(tick_count[0]) == 32'h0000_0000)
    else $error("trigger without zero count");
  irq_flag_a: assert property (tick_irq[0] |-> tick_flag[0])
    else $error("irq without flag");
  flag_hold_a: assert property (tick_flag[0] && !tick_flag_clear[0] |=> tick_flag[0])
    else $error("flag lost without clear");
  stop_hold_a: assert property ((stop_mode && tick_enable[0])[*2] |-> $stable(tick_count[0]))
    else $error("system channel ran in stop");
  wake_src_a: assert property ($rose(wake_request) |-> $past(stop_mode))
    else $error("wake outside stop");
  mon_step_a: assert property ($changed(monitor_count) |->
    monitor_count == $past(monitor_count) + 32'h0000_0001)
    else $error("monitor count jumped");
  freeze_a: assert property ((monitor_debug_freeze && debug_halt)[*2] |-> $stable(monitor_count))
    else $error("count ran while frozen");
  cmp_set_a: assert property ($rose(cmp_flag[0]) |-> $past(monitor_count) == cmp_value[0])
    else $error("compare flag at wrong count");
  cmp_irq_a: assert property (cmp_irq[0] |-> cmp_flag[0])
    else $error("compare irq without flag");
endmodule
bind system_tick_and_task_timers timers_props chk_u (.*);
`default_nettype wire

/* test/irq_sink.sv */
/* interrupt controller and queue trigger model: counts events, services irqs.
   a service clears the tick flags whose irqs are raised, after delay cycles. */
`timescale 1ns/1ns
`default_nettype none
module irq_sink (
  input wire logic core_clk,
  input wire logic [2:0] delay,
  input wire logic [4:0] tick_irq,
  input wire logic [4:0] tick_trigger,
  output var logic [4:0] flag_clear,
  output var int irq_seen,
  output var int trig_seen
);
  logic [2:0] wait_cnt = 3'h0;
  initial flag_clear = 5'h00;
  initial irq_seen = 0;
  initial trig_seen = 0;
  // guard on flag_clear: the flag needs a cycle to fall after service
  always @(posedge core_clk) begin
    trig_seen <= trig_seen + $countones(tick_trigger);
    flag_clear <= 5'h00;
    wait_cnt <= |tick_irq ? wait_cnt + 3'h1 : 3'h0;
    if (|tick_irq && flag_clear == 5'h00 && wait_cnt >= delay) begin
      flag_clear <= tick_irq;
      irq_seen <= irq_seen + 1;
      wait_cnt <= 3'h0;
    end
  end
endmodule
`default_nettype wire

/* test/system_tick_and_task_timers_tb.sv */
/* self-checking bench for the system timers.
   assumes the partner model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module system_tick_and_task_timers_tb;
  logic core_clk = 0, resetn = 0, xtal_clk = 0, stop_mode = 0, debug_halt = 0;
  logic [4:0] tick_enable = '0, tick_irq_enable = '0, tick_trig_enable = '0;
  logic [4:0] tick_flag_clear, tick_flag, tick_irq, tick_trigger;
  logic [4:0][31:0] tick_load = '0, tick_count;
  logic wake_request, monitor_enable = 0, monitor_debug_freeze = 0, cf_d = 0;
  logic [7:0] monitor_prescale = '0;
  logic [3:0] cmp_enable = '0, cmp_flag_clear = '0, cmp_flag, cmp_irq;
  logic [3:0][31:0] cmp_value = '0;
  logic [31:0] monitor_count, saved, rnd = 32'h0000_ffc5, exp_q[$];
  logic [2:0] delay = 3'h0;
  int err_total = 0, n_tests = 0, irq_seen, trig_seen, cyc = 0, last = -1, i0, t0;
  always #50 core_clk = ~core_clk;
  always #433 xtal_clk = ~xtal_clk; // crystal free-running, unrelated phase
  system_tick_and_task_timers dut_u (.*);
  irq_sink sink_u (.core_clk(core_clk), .delay(delay), .tick_irq(tick_irq),
    .tick_trigger(tick_trigger), .flag_clear(tick_flag_clear), .irq_seen(irq_seen),
    .trig_seen(trig_seen));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic waited(input string nm, input logic ok);
    chk(nm, {31'h0, ok}, 32'h0000_0001);
    if (ok !== 1'b1) finish_test;
  endtask
  // result watcher: takes the oldest note when a result appears
  always @(negedge core_clk) begin
    cyc++;
    if (tick_trigger[0] === 1'b1) begin
      if (last >= 0 && exp_q.size() > 0) chk("tick period", 32'(cyc - last), exp_q.pop_front());
      last = cyc;
    end
    if (cmp_flag[0] === 1'b1 && !cf_d && exp_q.size() > 0) chk("cmp count", monitor_count, exp_q.pop_front());
    cf_d = cmp_flag[0];
  end
  initial begin
    repeat (6) @(negedge core_clk);
    resetn = 1;
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      tick_load[0] = {29'h0, rnd[2:0]} + 32'h0000_0002;
      tick_trig_enable[0] = 1;
      last = -1;
      tick_enable[0] = 1;
      repeat (2) exp_q.push_back(tick_load[0] + 32'h0000_0001);
      for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(negedge core_clk);
      waited("tick periods", exp_q.size() == 0);
      tick_enable[0] = 0;
      @(negedge core_clk);
    end
    $display("tick period test done");
    tick_load[0] = 32'h0000_0003;
    for (int m = 0; m < 4; m++) begin
      {tick_trig_enable[0], tick_irq_enable[0]} = 2'(m);
      delay = 3'(m * 2);
      i0 = irq_seen;
      t0 = trig_seen;
      tick_enable[0] = 1;
      repeat (14) @(negedge core_clk);
      tick_enable[0] = 0;
      @(negedge core_clk);
      chk("irq service", {31'h0, irq_seen > i0}, 32'(m & 1));
      chk("trigger seen", {31'h0, trig_seen > t0}, 32'(m >> 1));
    end
    $display("event mode test done");
    tick_load[4] = 32'h0000_0001;
    tick_load[0] = 32'h0000_0005;
    tick_enable = 5'h11;
    stop_mode = 1;
    repeat (2) @(negedge core_clk);
    saved = tick_count[0];
    for (int i = 0; i < 200 && wake_request !== 1'b1; i++) @(negedge core_clk);
    waited("wake request", wake_request);
    chk("ch0 held in stop", tick_count[0], saved);
    stop_mode = 0;
    repeat (2) @(negedge core_clk);
    chk("wake released", {31'h0, wake_request}, 32'h0000_0000);
    tick_enable = 5'h00;
    $display("stop wake test done");
    rnd = xs(rnd);
    monitor_prescale = {6'h0, rnd[1:0]};
    cmp_value[0] = {28'h0, rnd[7:4]} + 32'h0000_0003;
    cmp_enable[0] = 1;
    exp_q.push_back(cmp_value[0] + 32'h0000_0001);
    monitor_enable = 1;
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge core_clk);
    waited("compare event", exp_q.size() == 0);
    chk("cmp irq", {31'h0, cmp_irq[0]}, 32'h0000_0001);
    monitor_debug_freeze = 1;
    debug_halt = 1;
    @(negedge core_clk);
    saved = monitor_count;
    repeat (6) @(negedge core_clk);
    chk("frozen count", monitor_count, saved);
    cmp_flag_clear = 4'h1;
    @(negedge core_clk);
    cmp_flag_clear = 4'h0;
    @(negedge core_clk);
    chk("cmp flag clear", {31'h0, cmp_flag[0]}, 32'h0000_0000);
    chk("cmp irq clear", {31'h0, cmp_irq[0]}, 32'h0000_0000);
    $display("task monitor test done");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
